// File: src/lcm_cell.sv
// One configurable logic cell with register bank on Avalon-MM.
// Assumes neighbour cells drive carry and cascade inputs, and
// that group clear, preset, sync clear and load are shared.
//
// How it works
// - One of normal, arithmetic, counter modes
// - Seven inputs: four data, feedback, carry, cascade
// - Clock, clears and load come from group
// - Normal: one 4-input table, carry or c
// - Normal: table output ANDed with cascade chain
// - Arithmetic: first 3-input table makes sum
// - Arithmetic: second table makes carry, cascade kept
// - Counter: enable or direction from data inputs
// - Counter: count table, carry table, mux, AND; here fixed count and carry logic, mask unused
// - Sync clear or load beats cascade value
// - Sync clear beats sync load
// - Load of own output holds the count
// - Second cell: carry from own register
// - Bus emulation: contention low, idle high
// - Either group control line drives clear/preset
// - Async clear doubles as preset, set statically
// - Clear lines active low, unused held high
// - First group cell stays out of carry
// - Carry feeds table and next carry logic
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module lcm_cell
   import lcm_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   input  wire logic [AVS_AW-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [AVS_DW-1:0]   avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic      [AVS_DW-1:0]   avs_readdata,
   output logic                     avs_waitrequest,
   input  wire logic                operand_in_a,
   input  wire logic                operand_in_b,
   input  wire logic                operand_in_c,
   input  wire logic                operand_in_d,
   input  wire logic                carry_in,
   input  wire logic                casc_in,
   input  wire logic                group_ctrl_a,
   input  wire logic                group_ctrl_b,
   input  wire logic                group_sclr,
   input  wire logic                group_sload,
   input  wire logic [TRI_N-1:0]    tri_en,
   input  wire logic [TRI_N-1:0]    tri_dat,
   output logic                     tri_out,
   output logic                     carry_out,
   output logic                     casc_out,
   output logic                     cell_out,
   output logic                     reg_q
);

   logic                rst_n_s;
   logic                ack_r;
   logic                req;
   logic                wr_go;
   logic                rd_go;
   logic [AVS_DW-1:0]   rdata_r;
   logic [AVS_DW-1:0]   rd_word;
   lcm_cfg_t            cfg_r;
   logic [LUT_W-1:0]    mask_r;
   lcm_stat_t           stat;
   logic                clr_n;
   logic                cell_arst_n;
   logic                q_raw_r;
   logic                q_nxt;
   logic                cin_eff;
   logic                cnt_en;
   logic                cnt_up;
   logic                fn;
   logic                cy;
   logic                casc_val;
   logic                ld_val;

   lcm_rst_sync u_rst (
      .clk     (clk),
      .rstn    (rstn),
      .rst_n_s (rst_n_s)
   );

   lcm_tri_emu #(
      .N (TRI_N)
   ) u_tri (
      .en  (tri_en),
      .dat (tri_dat),
      .bus (tri_out)
   );

   // ---------------- Avalon-MM slave ----------------
   // Each access waits one cycle while ce stays high; simple and fixed
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_go           = avs_write & ack_r;
   assign rd_go           = avs_read & ~ack_r;
   assign avs_readdata    = rdata_r;

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ack_r <= 1'b0;
      end else if (ce) begin
         ack_r <= req & ~ack_r;
      end
   end

   always_comb begin
      rd_word = '0;
      case (avs_address)
         OFS_CFG:  rd_word = AVS_DW'(cfg_r);
         OFS_MASK: rd_word = AVS_DW'(mask_r);
         OFS_STAT: rd_word = AVS_DW'(stat);
         default:  rd_word = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         rdata_r <= '0;
      end else if (ce && rd_go) begin
         rdata_r <= rd_word;
      end
   end

   // Mode and options are meant to be set before use
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cfg_r <= CFG_RST;
      end else if (ce && wr_go && avs_address == OFS_CFG) begin
         if (avs_byteenable[0]) begin
            cfg_r[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            cfg_r[CFG_W-1:8] <= avs_writedata[CFG_W-1:8];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         mask_r <= MASK_RST;
      end else if (ce && wr_go && avs_address == OFS_MASK) begin
         if (avs_byteenable[0]) begin
            mask_r[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            mask_r[15:8] <= avs_writedata[15:8];
         end
      end
   end

   assign stat = '{tri_out:   tri_out,
                   casc_out:  casc_out,
                   carry_out: carry_out,
                   fn_out:    casc_val,
                   q:         reg_q};

   // ---------------- Clear and preset ----------------
   // Selected group line, the other one treated as high
   always_comb begin
      if (!cfg_r.clr_use) begin
         clr_n = 1'b1;
      end else if (cfg_r.clr_src) begin
         clr_n = group_ctrl_b;
      end else begin
         clr_n = group_ctrl_a;
      end
   end

   // Gating the reset path; the selection is static in use
   assign cell_arst_n = rst_n_s & clr_n;

   // Preset is a clear of the inverted stored value
   always_ff @(posedge clk or negedge cell_arst_n) begin
      if (!cell_arst_n) begin
         q_raw_r <= 1'b0;
      end else if (ce) begin
         q_raw_r <= q_nxt ^ cfg_r.preset_mode;
      end
   end

   assign reg_q = q_raw_r ^ cfg_r.preset_mode;

   // ---------------- Datapath ----------------
   always_comb begin
      if (cfg_r.first_cell) begin
         cin_eff = 1'b0;
      end else if (cfg_r.fast_fb && cfg_r.mode == LCM_COUNT) begin
         cin_eff = reg_q;
      end else begin
         cin_eff = carry_in;
      end
   end

   // Only one of enable or direction is taken from the input
   assign cnt_en = cfg_r.cnt_dir ? 1'b1 : operand_in_a;
   assign cnt_up = cfg_r.cnt_dir ? operand_in_a : 1'b1;

   always_comb begin
      fn = 1'b0;
      cy = 1'b0;
      case (cfg_r.mode)
         LCM_NORMAL: begin
            fn = lcm_lut(mask_r, {operand_in_d,
                                  cfg_r.cin_sel ? cin_eff
                                                : operand_in_c,
                                  operand_in_b,
                                  operand_in_a});
         end
         LCM_ARITH: begin
            fn = lcm_lut(mask_r, {1'b0, cin_eff,
                                  operand_in_b,
                                  operand_in_a});
            cy = lcm_lut(mask_r, {1'b1, cin_eff,
                                  operand_in_b,
                                  operand_in_a});
         end
         LCM_COUNT: begin
            fn = reg_q ^ (cin_eff & cnt_en);
            cy = cin_eff & cnt_en
                 & (cnt_up ? reg_q : ~reg_q);
         end
         default: begin
            fn = 1'b0;
            cy = 1'b0;
         end
      endcase
   end

   assign casc_val  = cfg_r.casc_en ? (fn & casc_in) : fn;
   assign casc_out  = casc_val;
   assign carry_out = cfg_r.first_cell ? 1'b0 : cy;

   assign ld_val = cfg_r.load_hold ? reg_q : operand_in_b;

   // Load mux, then the clearing AND gate
   always_comb begin
      if (group_sclr) begin
         q_nxt = 1'b0;
      end else if (group_sload) begin
         q_nxt = ld_val;
      end else begin
         q_nxt = casc_val;
      end
   end

   // Comb path when the register is bypassed
   assign cell_out = cfg_r.reg_out ? reg_q : casc_val;

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_s);

   sequence s_bus_wait;
      req && avs_waitrequest && ce;
   endsequence

   sequence s_sclr;
      ce && group_sclr && clr_n;
   endsequence

   sequence s_load;
      ce && group_sload && !group_sclr && clr_n;
   endsequence

   sequence s_count_up;
      ce && cfg_r.mode == LCM_COUNT && cfg_r.cnt_dir
      && operand_in_a && !cfg_r.casc_en && !cfg_r.first_cell
      && !cfg_r.fast_fb && carry_in && !group_sclr
      && !group_sload && clr_n;
   endsequence

   a_bus_answer_one: assert property (
      s_bus_wait ##1 req |-> !avs_waitrequest)
      else $error("bus answer not after one wait cycle");

   a_sclr_wins: assert property (
      s_sclr ##1 (clr_n && $stable(cfg_r)) |-> !reg_q)
      else $error("sync clear did not clear register");

   a_load_value: assert property (
      s_load ##1 (clr_n && $stable(cfg_r)) |-> reg_q == $past(ld_val))
      else $error("sync load value not taken");

   a_load_holds_q: assert property (
      (s_load and cfg_r.load_hold) ##1 (clr_n && $stable(cfg_r))
      |-> $stable(reg_q))
      else $error("load as enable did not hold value");

   a_count_up_step: assert property (
      s_count_up ##1 (clr_n && $stable(cfg_r))
      |-> reg_q != $past(reg_q))
      else $error("enabled counter did not toggle");

   a_first_no_carry: assert property (
      cfg_r.first_cell |-> !carry_out)
      else $error("first cell drove carry out");

   a_async_clear: assert property (
      !clr_n |-> reg_q == cfg_r.preset_mode)
      else $error("async clear or preset not applied");

   a_adder_ok: assert property (
      cfg_r.mode == LCM_ARITH && mask_r == ADD_MASK
      && casc_in && !cfg_r.first_cell
      |-> casc_out == (operand_in_a ^ operand_in_b ^ carry_in)
      && carry_out == ((operand_in_a & operand_in_b)
                       | (carry_in & (operand_in_a ^ operand_in_b))))
      else $error("adder sum or carry wrong");

   a_tri_idle_high: assert property (
      tri_en == '0 |-> tri_out)
      else $error("idle emulated bus not high");

   a_tri_fight_low: assert property (
      $countones(tri_en) > 1 |-> !tri_out)
      else $error("contended emulated bus not low");

   a_casc_and: assert property (
      cfg_r.mode == LCM_NORMAL && cfg_r.casc_en && !casc_in
      |-> !casc_out)
      else $error("cascade low did not force output low");

endmodule

// File: src/lcm_pkg.sv
// Shared constants, register layout and types of the logic cell.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package lcm_pkg;

   localparam int             AVS_AW    = 4;
   localparam int             AVS_DW    = 32;
   localparam logic [3:0]     OFS_CFG   = 4'h0;
   localparam logic [3:0]     OFS_MASK  = 4'h4;
   localparam logic [3:0]     OFS_STAT  = 4'h8;
   localparam int             LUT_W     = 16;
   localparam logic [15:0]    MASK_RST  = 16'h0000;
   // Full adder: sum in low half, carry in high half
   localparam logic [15:0]    ADD_MASK  = 16'hE896;
   localparam int             TRI_N     = 4;
   localparam int             SYNC_LEN  = 2;

   typedef enum logic [1:0] {
      LCM_NORMAL,
      LCM_ARITH,
      LCM_COUNT
   } lcm_mode_t;

   // Configuration word, bit 0 upward from mode
   typedef struct packed {
      logic      load_hold;
      logic      fast_fb;
      logic      first_cell;
      logic      cnt_dir;
      logic      preset_mode;
      logic      clr_use;
      logic      clr_src;
      logic      reg_out;
      logic      casc_en;
      logic      cin_sel;
      lcm_mode_t mode;
   } lcm_cfg_t;

   localparam int       CFG_W   = $bits(lcm_cfg_t);
   localparam lcm_cfg_t CFG_RST = '0;

   typedef struct packed {
      logic tri_out;
      logic casc_out;
      logic carry_out;
      logic fn_out;
      logic q;
   } lcm_stat_t;

   localparam int STAT_W = $bits(lcm_stat_t);

   function automatic logic lcm_lut(input logic [15:0] mask,
                                    input logic [3:0]  sel);
      return mask[sel];
   endfunction

endpackage

// File: src/lcm_rst_sync.sv
// Reset release synchroniser for the logic cell.
// Assumes rstn may fall at any time; release is timed to clk.
`timescale 1ns/10ps
module lcm_rst_sync
   import lcm_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   output logic      rst_n_s
);

   logic [SYNC_LEN-1:0] sync_r;

   // Not gated by the clock enable, so reset can always end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_r <= '0;
      end else begin
         sync_r <= {sync_r[SYNC_LEN-2:0], 1'b1};
      end
   end

   assign rst_n_s = sync_r[SYNC_LEN-1];

endmodule

// File: src/lcm_tri_emu.sv
// Selector that stands in for an internal three-state bus.
// Assumes every enable and data bit is synchronous to the clock.
`timescale 1ns/10ps
module lcm_tri_emu
   import lcm_pkg::*;
#(
   parameter int N = TRI_N
)(
   input  wire logic [N-1:0] en,
   input  wire logic [N-1:0] dat,
   output logic              bus
);

   if (N < 2) begin : g_chk
      $error("lcm_tri_emu needs at least two drivers");
   end

   int unsigned n_on;

   // Contention resolves low, an idle bus high
   always_comb begin
      n_on = $countones(en);
      if (n_on == 0) begin
         bus = 1'b1;
      end else if (n_on > 1) begin
         bus = 1'b0;
      end else begin
         bus = |(en & dat);
      end
   end

endmodule

// File: tb/lcm_grp_model.sv
// Neighbour cell and shared group control lines.
// Assumes the bench sets requests just after a clock edge.
`timescale 1ns/10ps
module lcm_grp_model (
   input  wire logic prev_carry,
   input  wire logic prev_casc,
   input  wire logic clr_req,
   input  wire logic clr_line,
   input  wire logic sclr_req,
   input  wire logic sload_req,
   output logic      carry_in,
   output logic      casc_in,
   output logic      group_ctrl_a,
   output logic      group_ctrl_b,
   output logic      group_sclr,
   output logic      group_sload
);
   // Chain bits straight from the lower-order cell
   assign carry_in     = prev_carry;
   assign casc_in      = prev_casc;
   // Active low; the idle line is parked high
   assign group_ctrl_a = ~(clr_req & ~clr_line);
   assign group_ctrl_b = ~(clr_req & clr_line);
   // Hits every register; mates join the counter
   assign group_sclr   = sclr_req;
   assign group_sload  = sload_req;
endmodule

// File: tb/tb.sv
// Self-checking bench for the logic cell.
// Assumes the group model stands in for neighbour cells.
`timescale 1ns/10ps
module tb;
   import lcm_pkg::*;
   localparam logic [15:0] TMASK = 16'hA5C3;
   localparam logic [5:0]  PAT   = 6'h2D;
   logic              clk, rstn, avs_read, avs_write, avs_waitrequest;
   logic [AVS_AW-1:0] avs_address;
   logic [AVS_DW-1:0] avs_writedata, avs_readdata, rdv;
   logic [3:0]        opd, tri_en, tri_dat, ix;
   logic              p_carry, p_casc, clr_req, clr_line, sclr_req;
   logic              sload_req, q, en, up, carry_in, casc_in;
   logic              group_ctrl_a, group_ctrl_b, group_sclr, group_sload;
   logic              tri_out, carry_out, casc_out, cell_out, reg_q;
   int                err_total, n_compared;

   lcm_grp_model grp_u (.prev_carry(p_carry), .prev_casc(p_casc),
      .clr_req(clr_req), .clr_line(clr_line), .sclr_req(sclr_req),
      .sload_req(sload_req), .carry_in(carry_in), .casc_in(casc_in),
      .group_ctrl_a(group_ctrl_a), .group_ctrl_b(group_ctrl_b),
      .group_sclr(group_sclr), .group_sload(group_sload));
   lcm_cell dut_u (.clk(clk), .rstn(rstn), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .operand_in_a(opd[0]),
      .operand_in_b(opd[1]), .operand_in_c(opd[2]), .operand_in_d(opd[3]),
      .carry_in(carry_in), .casc_in(casc_in), .group_ctrl_a(group_ctrl_a),
      .group_ctrl_b(group_ctrl_b), .group_sclr(group_sclr),
      .group_sload(group_sload), .tri_en(tri_en), .tri_dat(tri_dat),
      .tri_out(tri_out), .carry_out(carry_out), .casc_out(casc_out),
      .cell_out(cell_out), .reg_q(reg_q));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask

   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         err_total++;
         final_report();
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, rdv, e);
   endtask

   // Sync clear held across the config write, so the count starts at 0
   task automatic setc(input logic [11:0] c, input logic pc, pk);
      @(posedge clk);
      sclr_req <= 1'b1;
      p_carry  <= pc;
      p_casc   <= pk;
      bus(1'b1, OFS_CFG, {20'h0, c});
      q = 1'b0;
   endtask

   // Register check shows the previous step's inputs
   task automatic step(input logic [3:0] o, input logic sc, sl, eq, ec);
      @(posedge clk);
      opd       <= o;
      sclr_req  <= sc;
      sload_req <= sl;
      @(negedge clk);
      chk("reg_q", reg_q, eq);
      chk("carry_out", carry_out, ec);
   endtask

   initial begin
      err_total = 0;
      n_compared = 0;
      {rstn, avs_read, avs_write, avs_address, avs_writedata, opd, tri_en,
       tri_dat, p_carry, p_casc, clr_req, clr_line, sclr_req,
       sload_req} = '0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFS_CFG, 32'h0, "cfg");
      rd(OFS_MASK, {16'h0, MASK_RST}, "mask");
      bus(1'b1, OFS_CFG, 32'hFFFF_FFFE);
      rd(OFS_CFG, 32'h0000_0FFE, "cfg");
      rd(4'hC, 32'h0, "unmapped");
      bus(1'b1, OFS_MASK, {16'hFFFF, TMASK});
      rd(OFS_MASK, {16'h0, TMASK}, "mask");
      $display("Test registers finished");
      for (int s = 0; s < 3; s++) begin
         bus(1'b1, OFS_CFG, 32'(4 * s));
         for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            opd     <= i[3:0];
            p_carry <= i[4];
            p_casc  <= i[4];
            ix = (s == 1) ? {i[3], i[4], i[1:0]} : i[3:0];
            @(negedge clk);
            chk("cell_out", cell_out, TMASK[ix] & (s != 2 || i[4]));
         end
      end
      $display("Test normal finished");
      bus(1'b1, OFS_MASK, {16'h0, ADD_MASK});
      bus(1'b1, OFS_CFG, 32'h9);
      p_casc <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         opd     <= {~i[0], ~i[1], i[1:0]};
         p_carry <= i[2];
         @(negedge clk);
         chk("sum", cell_out, ^i[2:0]);
         en = (i[0] & i[1]) | (i[2] & (i[0] | i[1]));
         chk("carry", carry_out, en);
      end
      bus(1'b1, OFS_CFG, 32'h19);
      p_carry <= 1'b0;
      step(4'h1, 0, 0, 0, 0);
      step(4'h0, 0, 0, 1, 0);
      step(4'h3, 0, 0, 0, 1);
      $display("Test arithmetic finished");
      for (int m = 0; m < 2; m++) begin
         setc(m ? 12'h102 : 12'h002, 1'b1, 1'b1);
         for (int k = 0; k < 6; k++) begin
            en = m ? 1'b1 : PAT[k];
            up = m ? PAT[k] : 1'b1;
            step({3'h0, PAT[k]}, 0, 0, q, en & (up ? q : ~q));
            q ^= en;
         end
      end
      setc(12'h00A, 1'b0, 1'b0);
      step(4'h2, 0, 1, 0, 0);
      step(4'h2, 1, 1, 1, 0);
      step(4'h2, 0, 1, 0, 0);
      step(4'h2, 1, 0, 1, 0);
      step(4'h0, 0, 0, 0, 0);
      setc(12'h802, 1'b1, 1'b1);
      step(4'h1, 0, 0, 0, 0);
      step(4'h1, 0, 1, 1, 1);
      step(4'h1, 0, 1, 1, 1);
      step(4'h1, 0, 0, 1, 1);
      step(4'h0, 0, 0, 0, 0);
      setc(12'h402, 1'b0, 1'b1);
      step(4'h2, 0, 1, 0, 0);
      step(4'h1, 0, 0, 1, 1);
      step(4'h0, 0, 0, 0, 0);
      setc(12'h202, 1'b1, 1'b1);
      step(4'h2, 0, 1, 0, 0);
      step(4'h1, 0, 0, 1, 0);
      step(4'h1, 0, 0, 1, 0);
      $display("Test counter finished");
      for (int v = 0; v < 4; v++) begin
         setc({4'h0, v[1], 1'b1, v[0], 5'h02}, 1'b0, 1'b1);
         // Load the opposite of the async value first, so it must change
         step({2'h0, ~v[1], 1'b0}, 0, 1, 0, 0);
         step(4'h0, 0, 0, ~v[1], 0);
         @(posedge clk);
         clr_line <= v[0];
         clr_req  <= 1'b1;
         @(negedge clk);
         chk("async", reg_q, v[1]);
         @(posedge clk);
         clr_req <= 1'b0;
      end
      $display("Test clear finished");
      for (int j = 0; j < 256; j++) begin
         @(posedge clk);
         tri_en  <= j[3:0];
         tri_dat <= j[7:4];
         en = (j[3:0] == 0) ? 1'b1 :
              ($countones(j[3:0]) > 1) ? 1'b0 : |(j[3:0] & j[7:4]);
         @(negedge clk);
         chk("tri_out", tri_out, en);
      end
      @(posedge clk);
      tri_en <= 4'h0;
      bus(1'b0, OFS_STAT, 32'h0);
      chk("stat", rdv & 32'h11, 32'h11);
      $display("Test bus finished");
      final_report();
   end
endmodule
